// *** rtl/fsd_sync_detect.sv ***
// fsk receive back end: post filter, slicer, bit sync and sync word match
//
// What this block does
// - post filter bandwidth is the 10-bit setting at setup bits 6..15
// - demodulator select 00 chooses the linear discriminator path
// - linear: frequency value filtered, enveloped, then threshold sliced
// - slicer decisions drive the oversampling bit synchronizer loop
// - one bandwidth field sets the post filter for both demodulators
// - sync detection enabled only for mode field 010 or 011
// - matching recovered bits against stored word raises the lock pin
// - lock pin drops by itself after nine recovered bit clocks
// - length field picks a 12, 16, 20 or 24 bit word
// - tolerance field accepts zero to three mismatching bits
// - synchronizer loop runs at 32 times the symbol rate
// - demodulator select 01 chooses the correlator path
module fsd_sync_detect
	import fsd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// axi4-lite write address and data
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// demodulator samples, same clock domain
	input wire fsd_sample_type sample,
	// recovered stream and pins
	output logic rx_data,
	output logic rx_bit_strobe,
	output logic int_lock,
	output logic irq
);

	// ==========================================================
	// helpers
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = data[i*8 +: 8];
		end
		return r;
	endfunction

	function automatic logic [4:0] popcount(input logic [WORD_W-1:0] v);
		logic [4:0] n;
		n = 5'h0;
		for (int i = 0; i < WORD_W; i++)
			n = n + {4'h0, v[i]};
		return n;
	endfunction

	function automatic logic signed [15:0] track(
		input logic signed [15:0] cur, input logic signed [15:0] tgt);
		logic signed [16:0] d;
		d = 17'(tgt) - 17'(cur);
		return cur + 16'(d >>> BW_FRAC);
	endfunction

	// ==========================================================
	// state
	fsd_state_type s;
	fsd_state_type next_s;

	logic [BW_W-1:0] bw;
	logic [1:0] sel;
	logic [2:0] mode;
	logic det_en;
	logic rx_en;
	logic signed [15:0] src;
	logic signed [17:0] diff;
	logic signed [28:0] prod;
	logic signed [16:0] thr;
	logic tick;
	logic bit_now;
	logic [WORD_W-1:0] hist_new;
	logic [WORD_W-1:0] len_mask;
	logic [4:0] errors;
	logic match;
	logic release_ev;
	logic [31:0] rd_val;
	logic rd_ok;
	logic wr_do;
	logic [1:0] ev;

	always_comb
	begin
		next_s = s;
		bw = s.demod_setup[BW_LSB +: BW_W];
		sel = s.demod_setup[SEL_LSB +: 2];
		mode = s.demod_setup[MODE_LSB +: 3];
		det_en = (mode == MODE_SYNC_A) || (mode == MODE_SYNC_B);
		rx_en = s.rx_clock[RXEN_BIT];

		// ======================================================
		// demodulator front: path select and post filter
		if (sel == SEL_LINEAR)
			src = sample.freq;
		else
			src = sample.corr;
		// one-pole step of bw/2^10 toward the input, both paths
		diff = 18'(src) - 18'(s.post_filt);
		prod = 29'(diff) * 29'($signed({1'b0, bw}));
		thr = (17'(s.env_hi) + 17'(s.env_lo)) >>> 1;
		if (sample.valid && rx_en)
		begin
			next_s.post_filt = s.post_filt + 16'(prod >>> BW_FRAC);
			if (sel == SEL_LINEAR)
			begin
				// envelope tracks extremes and leaks toward the signal
				if (s.post_filt > s.env_hi)
					next_s.env_hi = s.post_filt;
				else
					next_s.env_hi = s.env_hi -
						16'((17'(s.env_hi) - 17'(s.post_filt)) >>> ENV_SHIFT);
				if (s.post_filt < s.env_lo)
					next_s.env_lo = s.post_filt;
				else
					next_s.env_lo = s.env_lo +
						16'((17'(s.post_filt) - 17'(s.env_lo)) >>> ENV_SHIFT);
				next_s.slice = 17'(s.post_filt) > thr;
			end
			else if (sel == SEL_CORR)
				next_s.slice = s.post_filt > 16'sh0000;
			else
				next_s.slice = 1'b0;
		end
		// envelope relaxes toward zero while receive is off
		if (!rx_en)
		begin
			next_s.env_hi = track(s.env_hi, 16'sh0000);
			next_s.env_lo = track(s.env_lo, 16'sh0000);
		end

		// ======================================================
		// oversampling bit synchronizer
		tick = rx_en && (s.div_cnt == '0);
		if (!rx_en || s.div_cnt == '0)
			next_s.div_cnt = s.rx_clock[DIV_W-1:0] - 16'h1;
		else
			next_s.div_cnt = s.div_cnt - 16'h1;
		bit_now = 1'b0;
		if (tick)
		begin
			next_s.slice_prev = s.slice;
			next_s.phase = s.phase + 5'h1;
			// nudge phase toward zero at every slicer edge
			if (s.slice != s.slice_prev && s.phase != 5'h0)
			begin
				if (s.phase < MID_PHASE)
					next_s.phase = s.phase;
				else
					next_s.phase = s.phase + 5'h2;
			end
			bit_now = s.phase == MID_PHASE;
		end
		if (s.phase == OVERSAMPLE_LAST && tick && next_s.phase == 5'h1)
			next_s.phase = 5'h0;

		// ======================================================
		// sync word comparison
		hist_new = {s.history[WORD_W-2:0], s.slice};
		unique case (s.sync_cfg[LEN_LSB +: 2])
			2'h0: len_mask = 24'h000FFF;
			2'h1: len_mask = 24'h00FFFF;
			2'h2: len_mask = 24'h0FFFFF;
			default: len_mask = 24'hFFFFFF;
		endcase
		// newest bit is the word lsb, sent last
		errors = popcount((hist_new ^ s.sync_cfg[WORD_LSB +: WORD_W])
			& len_mask);
		match = bit_now && det_en &&
			(errors <= {3'h0, s.sync_cfg[TOL_LSB +: 2]});
		next_s.rx_bit_strobe = bit_now;
		release_ev = 1'b0;
		if (bit_now)
		begin
			next_s.history = hist_new;
			next_s.rx_data = s.slice;
			if (s.int_lock)
			begin
				if (s.hold_cnt == LOCK_HOLD_BITS - 4'h1)
				begin
					next_s.int_lock = 1'b0;
					release_ev = 1'b1;
				end
				next_s.hold_cnt = s.hold_cnt + 4'h1;
			end
		end
		// a fresh match restarts the hold window
		if (match)
		begin
			next_s.int_lock = 1'b1;
			next_s.hold_cnt = 4'h0;
			release_ev = 1'b0;
		end

		// ======================================================
		// axi4-lite write
		if (s_axi_awvalid && s.awready)
		begin
			next_s.aw_have = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
			next_s.awready = 1'b0;
		end
		if (s_axi_wvalid && s.wready)
		begin
			next_s.w_have = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
			next_s.wready = 1'b0;
		end
		wr_do = s.aw_have && s.w_have && !s.bvalid;
		ev = {release_ev, match};
		next_s.int_status = s.int_status | ev;
		if (wr_do)
		begin
			next_s.aw_have = 1'b0;
			next_s.w_have = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_OKAY;
			unique case (s.aw_addr & 8'hFC)
				ADDR_DEMOD_SETUP:
					next_s.demod_setup = merge(s.demod_setup, s.w_data, s.w_strb);
				ADDR_SYNC_CFG:
					next_s.sync_cfg = merge(s.sync_cfg, s.w_data, s.w_strb);
				ADDR_RX_CLOCK:
					next_s.rx_clock = merge(s.rx_clock, s.w_data, s.w_strb);
				ADDR_STATUS:
					next_s.bresp = RESP_OKAY;
				ADDR_INT_STATUS:
					if (s.w_strb[0])
						next_s.int_status = (s.int_status & ~s.w_data[1:0]) | ev;
				ADDR_INT_MASK:
					if (s.w_strb[0])
						next_s.int_mask = s.w_data[1:0];
				default:
					next_s.bresp = RESP_SLVERR;
			endcase
		end
		if (s.bvalid && s_axi_bready)
		begin
			next_s.bvalid = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end
		next_s.irq = |(next_s.int_status & next_s.int_mask);

		// ======================================================
		// axi4-lite read
		rd_ok = 1'b1;
		unique case (s_axi_araddr & 8'hFC)
			ADDR_DEMOD_SETUP: rd_val = s.demod_setup;
			ADDR_SYNC_CFG: rd_val = s.sync_cfg;
			ADDR_RX_CLOCK: rd_val = s.rx_clock;
			ADDR_STATUS: rd_val = {23'h0, s.phase, s.rx_data, s.slice,
				det_en, s.int_lock};
			ADDR_INT_STATUS: rd_val = {30'h0, s.int_status};
			ADDR_INT_MASK: rd_val = {30'h0, s.int_mask};
			default:
			begin
				rd_val = 32'h0000_0000;
				rd_ok = 1'b0;
			end
		endcase
		if (s_axi_arvalid && s.arready)
		begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rdata = rd_val;
			next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (s.rvalid && s_axi_rready)
		begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.demod_setup <= DEMOD_SETUP_RST;
			s.sync_cfg <= SYNC_CFG_RST;
			s.rx_clock <= RX_CLOCK_RST;
			s.int_status <= INT_RST;
			s.int_mask <= INT_RST;
		end
		else
			s <= next_s;
	end

	// ==========================================================
	// outputs, all from state flops
	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign rx_data = s.rx_data;
	assign rx_bit_strobe = s.rx_bit_strobe;
	assign int_lock = s.int_lock;
	assign irq = s.irq;

endmodule

// *** common/fsd_pkg.sv ***
// shared constants and types for the fsk demodulator and sync word detector
package fsd_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_DEMOD_SETUP = 8'h00;
	localparam logic [7:0] ADDR_SYNC_CFG = 8'h04;
	localparam logic [7:0] ADDR_RX_CLOCK = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h10;
	localparam logic [7:0] ADDR_INT_MASK = 8'h14;

	// ==========================================================
	// field positions
	localparam int SEL_LSB = 4;
	localparam int BW_LSB = 6;
	localparam int BW_W = 10;
	localparam int MODE_LSB = 23;
	localparam int LEN_LSB = 4;
	localparam int TOL_LSB = 6;
	localparam int WORD_LSB = 8;
	localparam int WORD_W = 24;
	localparam int DIV_W = 16;
	localparam int RXEN_BIT = 16;
	localparam int INT_MATCH = 0;
	localparam int INT_RELEASE = 1;

	// ==========================================================
	// reset values
	localparam logic [31:0] DEMOD_SETUP_RST = 32'h0000_0000;
	localparam logic [31:0] SYNC_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] RX_CLOCK_RST = 32'h0000_0001;
	localparam logic [1:0] INT_RST = 2'h0;

	// ==========================================================
	// codes and timing counts
	localparam logic [1:0] SEL_LINEAR = 2'h0;
	localparam logic [1:0] SEL_CORR = 2'h1;
	localparam logic [2:0] MODE_SYNC_A = 3'h2;
	localparam logic [2:0] MODE_SYNC_B = 3'h3;
	localparam logic [4:0] OVERSAMPLE_LAST = 5'h1F;
	localparam logic [4:0] MID_PHASE = 5'h10;
	localparam logic [3:0] LOCK_HOLD_BITS = 4'h9;
	localparam int BW_FRAC = 10;
	localparam int ENV_SHIFT = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// carriers
	typedef struct packed
	{
		logic valid;
		logic signed [15:0] freq;
		logic signed [15:0] corr;
	} fsd_sample_type;

	typedef struct packed
	{
		logic awready;
		logic wready;
		logic aw_have;
		logic w_have;
		logic [ADDR_W-1:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [31:0] demod_setup;
		logic [31:0] sync_cfg;
		logic [31:0] rx_clock;
		logic [1:0] int_status;
		logic [1:0] int_mask;
		logic irq;
		logic signed [15:0] post_filt;
		logic signed [15:0] env_hi;
		logic signed [15:0] env_lo;
		logic slice;
		logic slice_prev;
		logic [DIV_W-1:0] div_cnt;
		logic [4:0] phase;
		logic [WORD_W-1:0] history;
		logic rx_data;
		logic rx_bit_strobe;
		logic int_lock;
		logic [3:0] hold_cnt;
	} fsd_state_type;

endpackage

// *** tb/fsd_sync_detect_sva.sv ***
// port assertions for the sync word detector
module fsd_sync_detect_sva
	import fsd_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// stream
	input wire logic rx_data,
	input wire logic rx_bit_strobe,
	input wire logic int_lock
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	chk_lock_on_bit: assert property ($rose(int_lock) |-> rx_bit_strobe)
		else $error("lock rose off a bit strobe");
	chk_lock_drop_bit: assert property ($fell(int_lock) |-> rx_bit_strobe)
		else $error("lock fell off a bit strobe");
	chk_lock_held: assert property ($rose(int_lock) |=> int_lock[*8])
		else $error("lock pulse too short");
	chk_bit_spacing: assert property (rx_bit_strobe |=> !rx_bit_strobe[*8])
		else $error("bit strobes too close");
	chk_data_on_bit: assert property ($changed(rx_data) |-> rx_bit_strobe)
		else $error("data changed off a strobe");
	chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
	chk_w_blocked: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write taken while busy");
	chk_r_latency: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready) else $error("read answer late");
	chk_b_latency: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
endmodule

bind fsd_sync_detect fsd_sync_detect_sva chk (.ref_clk, .resetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.rx_data, .rx_bit_strobe, .int_lock);

// *** tb/fsd_tx_model.sv ***
// remote transmitter model: preamble, sync word and tail as samples
module fsd_tx_model
	import fsd_pkg::*;
#(
	parameter int BIT_CYCLES = 32
)
(
	// clock and frame request
	input wire logic ref_clk,
	input wire logic start,
	input wire logic [23:0] word,
	input wire logic [4:0] nbits,
	// demodulator side
	output fsd_sample_type sample,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic b;
	logic signed [15:0] v;
	initial
	begin
		sample = '0;
		busy = 1'h0;
		forever
		begin
			@(posedge ref_clk);
			if (start)
			begin
				busy <= 1'h1;
				for (int i = 0; i < 32 + nbits; i++)
				begin
					if (i < 16 || i >= 16 + nbits)
						b = i[0];
					else
						b = word[nbits + 15 - i];
					v = b ? 16'h1F40 : 16'hE0C0;
					sample <= {1'h1, v, v};
					repeat (BIT_CYCLES) @(posedge ref_clk);
				end
				busy <= 1'h0;
			end
			else
			begin
				// released line: no valid, value flips each cycle
				sample.valid <= 1'h0;
				sample.freq <= ~sample.freq;
				sample.corr <= ~sample.corr;
			end
		end
	end
endmodule

// *** tb/fsd_sync_detect_tb.sv ***
// testbench: bus tasks, transmitter model and scoreboard
module fsd_sync_detect_tb
	import fsd_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIV = 1;
	localparam logic [9:0] BW = 10'h097;
	logic ref_clk = 1'h0;
	logic resetn = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, rx_data, rx_bit_strobe, int_lock, irq, busy;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, w, cfg, su;
	fsd_sample_type sample;
	logic start = 1'h0, lock_prev = 1'h0;
	logic [23:0] word = 24'h0;
	logic [4:0] nbits = 5'h0C;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	logic [3:0] lock_q[$];
	int n_fail = 0, samples_checked = 0, cycles = 0, cnt = 0, seed = 30992;
	logic [7:0] ra[6] = '{ADDR_DEMOD_SETUP, ADDR_SYNC_CFG, ADDR_RX_CLOCK,
		ADDR_STATUS, ADDR_INT_STATUS, ADDR_INT_MASK};
	logic [31:0] rv[6] = '{DEMOD_SETUP_RST, SYNC_CFG_RST, RX_CLOCK_RST,
		32'h0, 32'h0, 32'h0};
	// sel, mode, length, tolerance, flipped bits, lock expected
	// the last case uses a select code that forces the slicer low
	logic [11:0] cs[7] = '{12'h501, 12'h1A1, 12'h54B, 12'h1FF, 12'h4E0,
		12'h5F6, 12'h880};

	fsd_sync_detect dut (.ref_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sample, .rx_data,
		.rx_bit_strobe, .int_lock, .irq);
	fsd_tx_model #(.BIT_CYCLES(32 * DIV)) tx (.ref_clk, .start, .word,
		.nbits, .sample, .busy);

	always #5 ref_clk = ~ref_clk;

	task automatic test_done();
		if (n_fail == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [33:0] e, input logic [33:0] g);
		samples_checked++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch at %0t: expected %h got %h", $time, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_awready === 1'h1)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
		@(posedge ref_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge ref_clk);
			if (s_axi_arready === 1'h1)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1);
		s_axi_rready <= 1'h0;
		@(posedge ref_clk);
	endtask

	// scoreboard: answers and lock pulses against queued notes
	always @(posedge ref_clk)
	begin
		cycles++;
		if (s_axi_rvalid === 1'h1 && s_axi_rready)
			chk(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid === 1'h1 && s_axi_bready)
			chk(34'(bq.pop_front()), 34'(s_axi_bresp));
		if (rx_bit_strobe === 1'h1 && lock_prev)
			cnt++;
		if (int_lock === 1'h1 && !lock_prev)
		begin
			cnt = 0;
			if (lock_q.size() == 0)
				chk(34'h0, 34'h1);
		end
		if (int_lock === 1'h0 && lock_prev && lock_q.size() > 0)
			chk(34'(lock_q.pop_front()), 34'(cnt));
		lock_prev <= (int_lock === 1'h1);
		if (cycles == 40000)
		begin
			n_fail++;
			test_done();
		end
	end

	initial
	begin
		repeat (2) @(posedge ref_clk);
		resetn <= 1'h1;
		@(posedge ref_clk);
		for (int i = 0; i < 6; i++)
			rd(ra[i], {RESP_OKAY, rv[i]});
		wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);
		rd(8'h18, {RESP_SLVERR, 32'h0});
		wr(ADDR_INT_MASK, 32'h1, RESP_OKAY);
		wr(ADDR_RX_CLOCK, 32'h0001_0000 | 32'(DIV), RESP_OKAY);
		foreach (cs[i])
		begin
			w = $random(seed);
			nbits <= 5'(12 + 4 * cs[i][6:5]);
			word <= w[23:0] ^ 24'((1 << cs[i][2:1]) - 1);
			cfg = {w[23:0], cs[i][4:3], cs[i][6:5], 4'h0};
			su = {6'h0, cs[i][9:7], 7'h0, BW, cs[i][11:10], 4'h0};
			wr(ADDR_SYNC_CFG, cfg, RESP_OKAY);
			wr(ADDR_DEMOD_SETUP, su, RESP_OKAY);
			rd(ADDR_SYNC_CFG, {RESP_OKAY, cfg});
			if (cs[i][0])
				lock_q.push_back(LOCK_HOLD_BITS);
			start <= 1'h1;
			@(posedge ref_clk);
			start <= 1'h0;
			// the 16 tail bits cover the nine-bit hold
			do @(posedge ref_clk); while (busy === 1'h1);
			chk(34'(lock_q.size()), 34'h0);
			lock_q.delete();
			chk(34'(cs[i][0]), 34'(irq));
			// frames end on a one; a forced-low slicer leaves zero
			chk(34'(!cs[i][11]), 34'(rx_data));
			rd(ADDR_INT_STATUS, {RESP_OKAY, 30'h0, cs[i][0], cs[i][0]});
			wr(ADDR_INT_STATUS, 32'h3, RESP_OKAY);
			@(posedge ref_clk);
			chk(34'h0, 34'(irq));
		end
		test_done();
	end
endmodule
